//--- design/scb_bank.sv
// Purpose: System control register bank behind an APB slave port
// Assumes: One clock, asynchronous active-high reset, aligned word offsets
// Notes: One wait-free access phase; unmapped addresses answer with pslverr
//
// Contract
// - Registers sit at fixed addresses in order
// - Auxiliary control word resets to zero
// - Bit 12 suppresses trace flush
// - Bit 11 disables dynamic read allocate
// - Bit 10 holds float exception outputs inactive
// - Bit 2 stops dual issue
// - Auxiliary reserved bits have no function
// - Identification: implementer and part number fields
// - Identification bits 23:20 give variant
// - Revision in 3:0, bits 19:16 ones
// - Fault status reachable as byte/halfword parts
// - Auxiliary fault status reads zero, ignores writes
// - Writing one sets nonmaskable pending; zero ignored
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "scb_cfg.svh"

module scb_bank
	import scb_pkg::*;
#(
	parameter logic [7:0] IMPLEMENTER = 8'h5a, // Arbitrary value
	parameter logic [3:0] VARIANT = 4'h1, // Arbitrary value
	parameter logic [11:0] PART_NUMBER = 12'h123, // Arbitrary value
	parameter logic [3:0] REVISION = 4'h2 // Arbitrary value
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave port
	input wire scb_apb_req_t apbReq,
	output scb_apb_rsp_t apbRsp,
	// Core control outputs
	output scb_aux_t auxCtrlOut,
	// Nonmaskable interrupt pending level toward the core
	output logic nmiPendingOut,
	// Core takes the nonmaskable handler, clearing pending
	input wire logic nmiTaken,
	// Hardware fault status bits to set (sticky)
	input wire logic [31:0] faultSet
);

	// ************************************************************
	// State
	// ************************************************************
	scb_state_t state_reg; // Registered state
	scb_state_t state_next; // Next state

	// Decode a word address to a register select
	function automatic scb_sel_t decode(input logic [31:0] a);
		logic [31:0] w;
		w = {a[31:2], 2'b00};
		unique case (w)
			`SCB_AUX_CTRL_ADDR: decode = SCB_SEL_AUX;
			`SCB_PROC_ID_ADDR: decode = SCB_SEL_ID;
			`SCB_INT_CTRL_ADDR: decode = SCB_SEL_INT;
			`SCB_VEC_BASE_ADDR: decode = SCB_SEL_VEC;
			`SCB_APP_RST_ADDR: decode = SCB_SEL_APP;
			`SCB_SYS_CTRL_ADDR: decode = SCB_SEL_SYS;
			`SCB_CFG_CTRL_ADDR: decode = SCB_SEL_CFG;
			`SCB_PRIO1_ADDR: decode = SCB_SEL_PR1;
			`SCB_PRIO2_ADDR: decode = SCB_SEL_PR2;
			`SCB_PRIO3_ADDR: decode = SCB_SEL_PR3;
			`SCB_HND_STATE_ADDR: decode = SCB_SEL_HND;
			`SCB_FAULT_STAT_ADDR: decode = SCB_SEL_FLT;
			`SCB_HARD_STAT_ADDR: decode = SCB_SEL_HARD;
			`SCB_MM_ADDR_ADDR: decode = SCB_SEL_MMA;
			`SCB_BUS_ADDR_ADDR: decode = SCB_SEL_BFA;
			`SCB_AUX_FAULT_ADDR: decode = SCB_SEL_AFS;
			default: decode = SCB_SEL_NONE;
		endcase
	endfunction : decode

	// Merge write data into a word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ************************************************************
	// Next-state logic
	// ************************************************************
	scb_sel_t sel; // Current decoded register
	logic access; // Access phase, always completes in one cycle
	logic wr; // Write taking effect this edge
	logic [31:0] rdata; // Read mux output
	logic [31:0] idWord; // Identification value

	// Fill the next state from the current state and the bus request
	always_comb
	begin
		state_next = state_reg;
		sel = decode(apbReq.paddr);
		access = apbReq.psel && apbReq.penable;
		wr = access && apbReq.pwrite;
		idWord = {IMPLEMENTER, VARIANT, `SCB_ID_CONST, PART_NUMBER,
			REVISION};
		rdata = 32'h00000000;
		// Read mux; reserved and write-only positions read zero
		unique case (sel)
			SCB_SEL_AUX: rdata = state_reg.auxCtrl;
			SCB_SEL_ID: rdata = idWord;
			SCB_SEL_INT: rdata = {state_reg.nmiPend, 31'h00000000};
			SCB_SEL_VEC: rdata = state_reg.vecBase;
			SCB_SEL_APP: rdata = state_reg.appRst;
			SCB_SEL_SYS: rdata = state_reg.sysCtrl;
			SCB_SEL_CFG: rdata = state_reg.cfgCtrl;
			SCB_SEL_PR1: rdata = state_reg.prio1;
			SCB_SEL_PR2: rdata = state_reg.prio2;
			SCB_SEL_PR3: rdata = state_reg.prio3;
			SCB_SEL_HND: rdata = state_reg.hndState;
			SCB_SEL_FLT: rdata = state_reg.faultStat;
			SCB_SEL_HARD: rdata = state_reg.hardStat;
			SCB_SEL_MMA: rdata = state_reg.mmAddr;
			SCB_SEL_BFA: rdata = state_reg.busAddr;
			SCB_SEL_AFS: rdata = 32'h00000000;
			SCB_SEL_NONE: rdata = 32'h00000000;
		endcase
		// Hardware sets fault status bits; set wins over clear
		state_next.faultStat = state_reg.faultStat | faultSet;
		// Core taking the handler clears the pending level
		if (nmiTaken)
		begin
			state_next.nmiPend = 1'b0;
		end
		// Register writes; only the four defined aux bits are stored
		if (wr && sel == SCB_SEL_AUX)
		begin
			state_next.auxCtrl = merge(state_reg.auxCtrl, apbReq.pwdata,
				apbReq.pstrb) & `SCB_AUX_CTRL_MASK;
		end
		if (wr && sel == SCB_SEL_INT && apbReq.pstrb[3]
			&& apbReq.pwdata[`SCB_NMI_PEND_BIT])
		begin
			state_next.nmiPend = 1'b1;
		end
		if (wr && sel == SCB_SEL_VEC)
		begin
			state_next.vecBase = merge(state_reg.vecBase, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_APP)
		begin
			state_next.appRst = merge(state_reg.appRst, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_SYS)
		begin
			state_next.sysCtrl = merge(state_reg.sysCtrl, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_CFG)
		begin
			state_next.cfgCtrl = merge(state_reg.cfgCtrl, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_PR1)
		begin
			state_next.prio1 = merge(state_reg.prio1, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_PR2)
		begin
			state_next.prio2 = merge(state_reg.prio2, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_PR3)
		begin
			state_next.prio3 = merge(state_reg.prio3, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_HND)
		begin
			state_next.hndState = merge(state_reg.hndState, apbReq.pwdata,
				apbReq.pstrb);
		end
		// Byte lanes reach the memory, bus and usage parts separately
		if (wr && sel == SCB_SEL_FLT)
		begin
			state_next.faultStat = merge(state_reg.faultStat, apbReq.pwdata,
				apbReq.pstrb) | faultSet;
		end
		if (wr && sel == SCB_SEL_HARD)
		begin
			state_next.hardStat = merge(state_reg.hardStat, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_MMA)
		begin
			state_next.mmAddr = merge(state_reg.mmAddr, apbReq.pwdata,
				apbReq.pstrb);
		end
		if (wr && sel == SCB_SEL_BFA)
		begin
			state_next.busAddr = merge(state_reg.busAddr, apbReq.pwdata,
				apbReq.pstrb);
		end
		// Answer registered: pready in the cycle after setup
		state_next.rsp.pready = apbReq.psel && !apbReq.penable;
		state_next.rsp.pslverr = apbReq.psel && !apbReq.penable
			&& sel == SCB_SEL_NONE;
		state_next.rsp.prdata = (apbReq.psel && !apbReq.penable
			&& !apbReq.pwrite) ? rdata : 32'h00000000;
		// Control outputs follow the stored auxiliary bits
		state_next.aux.traceFlushDisable =
			state_next.auxCtrl[`SCB_TRACE_FLUSH_BIT];
		state_next.aux.readAllocateDisable =
			state_next.auxCtrl[`SCB_READ_ALLOC_BIT];
		state_next.aux.floatExceptionOutputDisable =
			state_next.auxCtrl[`SCB_FLOAT_EXC_BIT];
		state_next.aux.dualIssueDisable =
			state_next.auxCtrl[`SCB_DUAL_ISSUE_BIT];
		state_next.nmiPending = state_next.nmiPend;
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Register the whole state; constants only under reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.auxCtrl <= `SCB_AUX_CTRL_RST;
			state_reg.nmiPend <= `SCB_INT_CTRL_RST;
			state_reg.appRst <= `SCB_APP_RST_RST;
			state_reg.cfgCtrl <= `SCB_CFG_CTRL_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign apbRsp = state_reg.rsp;
	assign auxCtrlOut = state_reg.aux;
	assign nmiPendingOut = state_reg.nmiPending;

endmodule : scb_bank

//--- design/scb_cfg.svh
// Purpose: Offsets, field positions, reset values of the control register bank
// Assumes: APB byte addresses, 32-bit aligned words
// Notes: Definitions only
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define SCB_AUX_CTRL_ADDR 32'he000e008
`define SCB_PROC_ID_ADDR 32'he000ed00
`define SCB_INT_CTRL_ADDR 32'he000ed04
`define SCB_VEC_BASE_ADDR 32'he000ed08
`define SCB_APP_RST_ADDR 32'he000ed0c
`define SCB_SYS_CTRL_ADDR 32'he000ed10
`define SCB_CFG_CTRL_ADDR 32'he000ed14
`define SCB_PRIO1_ADDR 32'he000ed18
`define SCB_PRIO2_ADDR 32'he000ed1c
`define SCB_PRIO3_ADDR 32'he000ed20
`define SCB_HND_STATE_ADDR 32'he000ed24
`define SCB_FAULT_STAT_ADDR 32'he000ed28
`define SCB_MM_STAT_ADDR 32'he000ed28
`define SCB_BUS_STAT_ADDR 32'he000ed29
`define SCB_USE_STAT_ADDR 32'he000ed2a
`define SCB_HARD_STAT_ADDR 32'he000ed2c
`define SCB_MM_ADDR_ADDR 32'he000ed34
`define SCB_BUS_ADDR_ADDR 32'he000ed38
`define SCB_AUX_FAULT_ADDR 32'he000ed3c

// ************************************************************
// Reset values
// ************************************************************
`define SCB_AUX_CTRL_RST 32'h00000000
`define SCB_INT_CTRL_RST 1'h0
`define SCB_APP_RST_RST 32'hfa050000
`define SCB_CFG_CTRL_RST 32'h00000200
`define SCB_ZERO_RST 32'h00000000

// ************************************************************
// Field positions and masks
// ************************************************************
`define SCB_TRACE_FLUSH_BIT 12
`define SCB_READ_ALLOC_BIT 11
`define SCB_FLOAT_EXC_BIT 10
`define SCB_DUAL_ISSUE_BIT 2
`define SCB_AUX_CTRL_MASK 32'h00001c04
`define SCB_NMI_PEND_BIT 31
`define SCB_ID_CONST 4'hf

`endif

//--- design/scb_pkg.sv
// Purpose: Types shared by the control register bank
// Assumes: APB with 32-bit data
// Notes: Constants live in scb_cfg.svh
package scb_pkg;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} scb_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} scb_apb_rsp_t;

	// Core control outputs from the auxiliary control word
	typedef struct packed {
		logic traceFlushDisable;
		logic readAllocateDisable;
		logic floatExceptionOutputDisable;
		logic dualIssueDisable;
	} scb_aux_t;

	// Decoded register select
	typedef enum {
		SCB_SEL_AUX, SCB_SEL_ID, SCB_SEL_INT, SCB_SEL_VEC, SCB_SEL_APP,
		SCB_SEL_SYS, SCB_SEL_CFG, SCB_SEL_PR1, SCB_SEL_PR2, SCB_SEL_PR3,
		SCB_SEL_HND, SCB_SEL_FLT, SCB_SEL_HARD, SCB_SEL_MMA, SCB_SEL_BFA,
		SCB_SEL_AFS, SCB_SEL_NONE
	} scb_sel_t;

	// Whole state of the bank
	typedef struct packed {
		logic [31:0] auxCtrl;
		logic nmiPend;
		logic [31:0] vecBase;
		logic [31:0] appRst;
		logic [31:0] sysCtrl;
		logic [31:0] cfgCtrl;
		logic [31:0] prio1;
		logic [31:0] prio2;
		logic [31:0] prio3;
		logic [31:0] hndState;
		logic [31:0] faultStat;
		logic [31:0] hardStat;
		logic [31:0] mmAddr;
		logic [31:0] busAddr;
		scb_apb_rsp_t rsp;
		scb_aux_t aux;
		logic nmiPending;
	} scb_state_t;

endpackage : scb_pkg

//--- tb/scb_bank_checker.sv
// Purpose: Port assertions for the control register bank
// Assumes: Zero-wait APB answers, registered outputs
// Notes: Bound into scb_bank below
`timescale 1ns/10ps
`include "scb_cfg.svh"

module scb_bank_checker
	import scb_pkg::*;
#(
	parameter logic [7:0] IMPLEMENTER = 8'h5a,
	parameter logic [3:0] VARIANT = 4'h1,
	parameter logic [11:0] PART_NUMBER = 12'h123,
	parameter logic [3:0] REVISION = 4'h2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus and core side
	input wire scb_apb_req_t apbReq,
	input wire scb_apb_rsp_t apbRsp,
	input wire scb_aux_t auxCtrlOut,
	input wire logic nmiPendingOut,
	input wire logic nmiTaken,
	input wire logic [31:0] faultSet
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Accepted access phases
	// ****
	sequence sDone;
		apbReq.psel && apbReq.penable && apbRsp.pready;
	endsequence
	sequence sWr(a);
		sDone ##0 apbReq.pwrite && apbReq.paddr == a;
	endsequence
	sequence sRd(a);
		sDone ##0 !apbReq.pwrite && apbReq.paddr == a;
	endsequence
	a_ready_after_setup: assert property (
		apbReq.psel && !apbReq.penable |=> apbRsp.pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (
		apbRsp.pready |=> !apbRsp.pready) else $error("ready too long");
	a_aux_reset_zero: assert property (
		$fell(rst) |-> auxCtrlOut == '0 && !nmiPendingOut)
		else $error("outputs not clear after reset");
	a_aux_follows_write: assert property (
		sWr(`SCB_AUX_CTRL_ADDR) ##0 apbReq.pstrb == 4'hf |=>
		auxCtrlOut == {$past(apbReq.pwdata[12]), $past(apbReq.pwdata[11]),
		$past(apbReq.pwdata[10]), $past(apbReq.pwdata[2])})
		else $error("aux outputs differ from write");
	a_aux_holds_value: assert property (
		!(apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
		&& apbReq.paddr == `SCB_AUX_CTRL_ADDR) |=> $stable(auxCtrlOut))
		else $error("aux outputs moved without write");
	a_id_read_value: assert property (
		sRd(`SCB_PROC_ID_ADDR) |-> apbRsp.prdata ==
		{IMPLEMENTER, VARIANT, 4'hf, PART_NUMBER, REVISION})
		else $error("identification word wrong");
	a_aux_fault_zero: assert property (
		sRd(`SCB_AUX_FAULT_ADDR) |-> apbRsp.prdata == '0 && !apbRsp.pslverr)
		else $error("aux fault status not zero");
	a_nmi_set_pending: assert property (
		sWr(`SCB_INT_CTRL_ADDR) ##0 apbReq.pwdata[31] && apbReq.pstrb[3]
		&& !nmiTaken |=> nmiPendingOut) else $error("nmi not pending");
	a_nmi_zero_noop: assert property (
		sWr(`SCB_INT_CTRL_ADDR) ##0 !apbReq.pwdata[31] && !nmiTaken
		|=> nmiPendingOut == $past(nmiPendingOut))
		else $error("zero write moved nmi");
	a_unmapped_error: assert property (
		sDone ##0 apbReq.paddr == 32'he000ed30 |->
		apbRsp.pslverr && apbRsp.prdata == '0)
		else $error("unmapped word not refused");
endmodule : scb_bank_checker

bind scb_bank scb_bank_checker #(.IMPLEMENTER(IMPLEMENTER),
	.VARIANT(VARIANT), .PART_NUMBER(PART_NUMBER), .REVISION(REVISION))
	scb_bank_checker_i (.clk(clk), .rst(rst), .apbReq(apbReq),
	.apbRsp(apbRsp), .auxCtrlOut(auxCtrlOut), .nmiPendingOut(nmiPendingOut),
	.nmiTaken(nmiTaken), .faultSet(faultSet));

//--- tb/testbench.sv
// Purpose: Self-checking bench for the control register bank
// Assumes: APB master tasks, one idle cycle between transfers
// Notes: Seeded random data with fixed corner values
`timescale 1ns/10ps
`include "scb_cfg.svh"

module testbench;
	import scb_pkg::*;
	localparam logic [7:0] IMPL = 8'h3c; // Arbitrary value
	localparam logic [3:0] VARNT = 4'h6; // Arbitrary value
	localparam logic [11:0] PART = 12'h9e1; // Arbitrary value
	localparam logic [3:0] REV = 4'h5; // Arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	scb_apb_req_t apbReq = '0;
	scb_apb_rsp_t apbRsp;
	scb_aux_t auxCtrlOut;
	logic nmiPendingOut;
	logic nmiTaken = 1'b0;
	logic [31:0] faultSet = '0;
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 32'h4bad2f6f;
	logic [31:0] rdata;
	logic err;
	logic [31:0] val;

	scb_bank #(.IMPLEMENTER(IMPL), .VARIANT(VARNT), .PART_NUMBER(PART),
		.REVISION(REV)) scb_bank_i (.clk(clk), .rst(rst), .apbReq(apbReq),
		.apbRsp(apbRsp), .auxCtrlOut(auxCtrlOut),
		.nmiPendingOut(nmiPendingOut), .nmiTaken(nmiTaken),
		.faultSet(faultSet));

	// 100 MHz clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	// ****
	// Helpers
	// ****
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, then one idle cycle
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: d, pstrb: s};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hung wait
		do
		begin
			@(posedge clk);
		end
		while (apbRsp.pready !== 1'b1);
		rdata = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, '0, 4'h0);
		chk(rdata, e);
	endtask : rd

	// Expected value of a word straight after reset
	function automatic logic [31:0] rstVal(input logic [31:0] a);
		case (a)
			`SCB_PROC_ID_ADDR: return {IMPL, VARNT, 4'hf, PART, REV};
			`SCB_APP_RST_ADDR: return 32'hfa050000;
			`SCB_CFG_CTRL_ADDR: return 32'h00000200;
			default: return 32'h00000000;
		endcase
	endfunction : rstVal

	// Expected control outputs for an auxiliary control word
	function automatic logic [31:0] auxOf(input logic [31:0] v);
		return {28'h0, v[12], v[11], v[10], v[2]};
	endfunction : auxOf

	// Watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`SCB_AUX_CTRL_ADDR, 32'h0);
		// Reset map, unmapped word refused
		for (logic [31:0] a = 32'he000ed00; a <= 32'he000ed3c; a += 4)
		begin
			rd(a, rstVal(a));
			chk({31'h0, err}, {31'h0, a == 32'he000ed30});
		end
		bus(1'b1, `SCB_PROC_ID_ADDR, $random(seed), 4'hf);
		rd(`SCB_PROC_ID_ADDR, rstVal(`SCB_PROC_ID_ADDR));
		// Aux control: all ones first, then random
		for (int i = 0; i < 12; i++)
		begin
			val = (i == 0) ? 32'hffffffff : $random(seed);
			bus(1'b1, `SCB_AUX_CTRL_ADDR, val, 4'hf);
			chk({28'h0, auxCtrlOut}, auxOf(val));
			rd(`SCB_AUX_CTRL_ADDR, val & 32'h00001c04);
		end
		// Plain storage words
		for (logic [31:0] a = 32'he000ed08; a <= 32'he000ed38; a += 4)
		begin
			val = $random(seed);
			bus(1'b1, a, val, 4'hf);
			rd(a, (a == 32'he000ed30) ? 32'h0 : val);
		end
		bus(1'b1, `SCB_AUX_FAULT_ADDR, $random(seed), 4'hf);
		rd(`SCB_AUX_FAULT_ADDR, 32'h0);
		// Fault status reached in parts, then a hardware set
		bus(1'b1, `SCB_FAULT_STAT_ADDR, 32'h0, 4'hf);
		bus(1'b1, `SCB_MM_STAT_ADDR, 32'h5a5a5a5a, 4'h1);
		bus(1'b1, `SCB_BUS_STAT_ADDR, 32'hc3c3c3c3, 4'h2);
		bus(1'b1, `SCB_USE_STAT_ADDR, 32'h96969696, 4'hc);
		rd(`SCB_FAULT_STAT_ADDR, 32'h9696c35a);
		faultSet <= 32'h00010000;
		@(posedge clk);
		faultSet <= '0;
		rd(`SCB_FAULT_STAT_ADDR, 32'h9697c35a);
		// Hardware set held across a clearing write: the set wins
		faultSet <= 32'h00000100;
		bus(1'b1, `SCB_FAULT_STAT_ADDR, 32'h0, 4'hf);
		faultSet <= '0;
		rd(`SCB_FAULT_STAT_ADDR, 32'h00000100);
		// Nonmaskable pending: zero ignored, one sets, taken clears
		bus(1'b1, `SCB_INT_CTRL_ADDR, 32'h7fffffff, 4'hf);
		rd(`SCB_INT_CTRL_ADDR, 32'h0);
		bus(1'b1, `SCB_INT_CTRL_ADDR, 32'h80000000, 4'hf);
		chk({31'h0, nmiPendingOut}, 32'h1);
		rd(`SCB_INT_CTRL_ADDR, 32'h80000000);
		nmiTaken <= 1'b1;
		@(posedge clk);
		nmiTaken <= 1'b0;
		@(posedge clk);
		chk({31'h0, nmiPendingOut}, 32'h0);
		// Reset in mid-run with aux bits and pending level set
		bus(1'b1, `SCB_AUX_CTRL_ADDR, 32'hffffffff, 4'hf);
		bus(1'b1, `SCB_INT_CTRL_ADDR, 32'h80000000, 4'hf);
		rst <= 1'b1;
		@(posedge clk);
		chk({28'h0, auxCtrlOut}, 32'h0);
		chk({31'h0, nmiPendingOut}, 32'h0);
		rst <= 1'b0;
		@(posedge clk);
		rd(`SCB_AUX_CTRL_ADDR, 32'h0);
		rd(`SCB_CFG_CTRL_ADDR, rstVal(`SCB_CFG_CTRL_ADDR));
		end_of_test();
	end
endmodule : testbench
